// [rtl/plc_link_regs.sv]
// Link capability, link control, link status and extended device
// capability registers of a single-lane endpoint.
// Assumes a configuration access port on core_clk, a nonvolatile word
// loader with strobe, and training status from the link logic.
// What this block does
// R1: Maximum link speed field bits 3:0 reads constant 0010b.
// R2: Maximum link width field bits 9:4 reports one lane, 000001b.
// R3: Power management support bits 11:10 read 11b, both L0s and L1.
// R4: L0s exit latency bits 14:12 come from word 0x18 by clock mode.
// R5: L1 exit latency bits 17:15 come from word 0x14 by clock mode.
// R6: Link capability bits 18 to 21 always read zero.
// R7: Power management optionality bit 22 reads one.
// R8: Port number bits 31:24 start zero, set during link training.
// R9: Control bits 1:0 writable, reset 00b, kept over function reset.
// R10: Receiver may enter L0s whatever the transmitter setting says.
// R11: Control bit 3 holds read completion boundary, 64 or 128 byte.
// R12: Control bits 4 and 5 are hardwired zero.
// R13: Control bit 6 common clock flag, writable, kept on function reset.
// R14: Control bit 7 extends fast training on L0s exit, kept on function reset.
// R15: Control bits 8 to 15 read zero.
// R16: Negotiated speed bits 3:0 read 0001b.
// R17: Negotiated width bits 9:4 read 000001b.
// R18: Status bit 11 set while training runs; bit 10 reads zero.
// R19: Status bit 12 slot clock, default one, loaded from word 0x1A.
// R20: Status bits 13 to 15 always read zero.
// R21: Extended capability only for version two or more; bit 11 reads one.
// R22: Extended bits 3:0 read 1111b and bit 4 reads one.
// R23: Writes to read-only fields are ignored; writable fields update.
`timescale 1ns/10ps
module plc_link_regs
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic flr_req,
  // Configuration access, dword addressed, byte enables
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output plc_pkg::plc_word_t cfg_rdata,
  output logic cfg_rvalid,
  // Nonvolatile loader
  input wire logic nv_load,
  input wire logic [7:0] nv_addr,
  input wire logic [15:0] nv_data,
  input wire logic [3:0] cap_version,
  // Link layer
  input wire logic train_active,
  input wire logic port_num_valid,
  input wire logic [7:0] port_num,
  input wire logic rx_l0s_req,
  output logic tx_l0s_en,
  output logic tx_l1_en,
  output logic rx_l0s_en,
  output logic ext_sync,
  output logic rcb_128,
  output logic common_clk
);
  import plc_pkg::*;
  `include "plc_regs.svh"

  typedef struct packed {
    logic [1:0] pm_ctrl;
    logic rcb;
    logic com_clk;
    logic ext_sync;
    logic [7:0] port;
    logic train_s1;
    logic train_s2;
    logic train_s3;
    logic train;
    logic [31:0] rdata;
    logic rvalid;
    logic tx_l0s;
    logic tx_l1;
    logic rx_l0s;
  } plc_state_t;

  plc_state_t s_q;
  plc_state_t s_d;

  logic [15:0] nv_word_l0s;
  logic [15:0] nv_deep_exit_word;
  logic [15:0] nv_word_clk;
  plc_lat_t l0s_lat;
  plc_lat_t l1_lat;
  plc_word_t link_ability_info;
  plc_half_t link_power_setup;
  plc_half_t link_state_report;
  plc_word_t device_ability_ext;
  logic [11:0] dw_addr;

  plc_nv_latch u_nv
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .nv_load(nv_load),
    .nv_addr(nv_addr),
    .nv_data(nv_data),
    .nv_word_l0s(nv_word_l0s),
    .nv_deep_exit_word(nv_deep_exit_word),
    .nv_word_clk(nv_word_clk)
  );

  // The common clock setting picks which latency slice of each word counts.
  assign l0s_lat = s_q.com_clk ?
    nv_word_l0s[`PLC_NV_L0S_COM_LSB +: 3] :
    nv_word_l0s[`PLC_NV_L0S_SEP_LSB +: 3]; // [R4] [R13]
  assign l1_lat = s_q.com_clk ?
    nv_deep_exit_word[`PLC_NV_L1_COM_LSB +: 3] :
    nv_deep_exit_word[`PLC_NV_L1_SEP_LSB +: 3]; // [R5]

  assign link_ability_info = {
    s_q.port,           // [R8]
    1'b0,
    `PLC_PM_OPTIONAL,   // [R7]
    4'h0,               // [R6]
    l1_lat,             // [R5]
    l0s_lat,            // [R4]
    `PLC_PM_SUPPORT,    // [R3]
    `PLC_MAX_WIDTH,     // [R2]
    `PLC_MAX_SPEED      // [R1]
  };

  assign link_power_setup = {
    8'h00,              // [R15]
    s_q.ext_sync,       // [R14]
    s_q.com_clk,        // [R13]
    2'h0,               // [R12]
    s_q.rcb,            // [R11]
    1'b0,
    s_q.pm_ctrl         // [R9]
  };

  assign link_state_report = {
    3'h0,                                  // [R20]
    nv_word_clk[`PLC_NV_SLOT_CLK_BIT],     // [R19]
    s_q.train,                             // [R18]
    1'b0,
    `PLC_NEG_WIDTH,                        // [R17]
    `PLC_NEG_SPEED                         // [R16]
  };

  assign device_ability_ext = {
    18'h00000,
    2'h0,
    `PLC_EXT_RSVD11,    // [R21]
    6'h00,
    `PLC_TMO_DISABLE_OK,// [R22]
    `PLC_TMO_RANGES     // [R22]
  };

  assign dw_addr = {cfg_addr[11:2], 2'h0};

  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = cfg_rd;
    // Training status arrives from another domain, so it is filtered.
    s_d.train_s1 = train_active;
    s_d.train_s2 = s_q.train_s1;
    s_d.train_s3 = s_q.train_s2;
    if (s_q.train_s2 == s_q.train_s3)
    begin
      s_d.train = s_q.train_s3; // [R18]
    end
    if (port_num_valid && s_q.train)
    begin
      s_d.port = port_num; // [R8]
    end
    // Only writable bits are taken; everything else in the word is dropped.
    if (cfg_wr && dw_addr == `PLC_OFS_LINK_POWER)
    begin
      if (cfg_be[0])
      begin
        s_d.pm_ctrl = cfg_wdata[1:0]; // [R9] [R23]
        s_d.rcb = cfg_wdata[3]; // [R11]
        s_d.com_clk = cfg_wdata[6]; // [R13]
        s_d.ext_sync = cfg_wdata[7]; // [R14]
      end
    end
    if (cfg_rd)
    begin
      case (dw_addr)
        `PLC_OFS_LINK_ABILITY: s_d.rdata = link_ability_info;
        `PLC_OFS_LINK_POWER: s_d.rdata = {link_state_report, link_power_setup};
        `PLC_OFS_DEV_ABILITY_EXT:
        begin
          // Older capability structures have no extended register.
          s_d.rdata = (cap_version >= `PLC_CAP_VER_MIN) ?
            device_ability_ext : 32'h00000000; // [R21]
        end
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    s_d.tx_l0s = s_q.pm_ctrl[0];
    s_d.tx_l1 = s_q.pm_ctrl[1];
    // The receiver ignores the transmit-side setting for L0s.
    s_d.rx_l0s = rx_l0s_req; // [R10]
  end

  // Function reset leaves the control bits alone; only rst_n clears them.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.pm_ctrl <= `PLC_PM_CTRL_RESET;
      s_q.port <= `PLC_PORT_RESET;
    end
    else if (flr_req)
    begin
      s_q <= s_d;
      s_q.port <= s_q.port;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata = s_q.rdata;
  assign cfg_rvalid = s_q.rvalid;
  assign tx_l0s_en = s_q.tx_l0s;
  assign tx_l1_en = s_q.tx_l1;
  assign rx_l0s_en = s_q.rx_l0s;
  assign ext_sync = s_q.ext_sync;
  assign rcb_128 = s_q.rcb;
  assign common_clk = s_q.com_clk;

  // Named steps shared by the checks below.
  sequence s_cap_read;
    cfg_rd && dw_addr == `PLC_OFS_LINK_ABILITY;
  endsequence
  sequence s_link_read;
    cfg_rd && dw_addr == `PLC_OFS_LINK_POWER;
  endsequence
  sequence s_ctrl_write;
    cfg_wr && cfg_be[0] && dw_addr == `PLC_OFS_LINK_POWER;
  endsequence
  // Four equal samples are enough for the filtered flag to follow the pin.
  sequence s_train_high;
    train_active [*4];
  endsequence
  sequence s_train_low;
    !train_active [*4];
  endsequence

  // Constant fields of the returned words.
  a_speed_fixed: assert property ( // [R1]
    @(posedge core_clk) disable iff (!rst_n)
    s_cap_read |=> cfg_rdata[9:0] == 10'h012)
    else $error("max speed or width wrong");
  a_pm_support: assert property ( // [R3]
    @(posedge core_clk) disable iff (!rst_n)
    s_cap_read |=> cfg_rdata[23:18] == 6'h10 && cfg_rdata[11:10] == 2'h3)
    else $error("capability constant bits wrong");
  a_ctrl_zero: assert property ( // [R15]
    @(posedge core_clk) disable iff (!rst_n)
    s_link_read |=> cfg_rdata[15:8] == 8'h00 && cfg_rdata[5:4] == 2'h0 &&
    cfg_rdata[31:29] == 3'h0 && cfg_rdata[26] == 1'b0)
    else $error("hardwired control or status bits set");
  a_status_fixed: assert property ( // [R16]
    @(posedge core_clk) disable iff (!rst_n)
    s_link_read |=> cfg_rdata[25:16] == 10'h011)
    else $error("negotiated speed or width wrong");
  a_ext_cap: assert property ( // [R22]
    @(posedge core_clk) disable iff (!rst_n)
    cfg_rd && dw_addr == `PLC_OFS_DEV_ABILITY_EXT &&
    cap_version >= `PLC_CAP_VER_MIN |=> cfg_rdata == 32'h0000081F)
    else $error("extended capability value wrong");
  a_ext_absent: assert property ( // [R21]
    @(posedge core_clk) disable iff (!rst_n)
    cfg_rd && dw_addr == `PLC_OFS_DEV_ABILITY_EXT &&
    cap_version < `PLC_CAP_VER_MIN |=> cfg_rdata == 32'h00000000)
    else $error("extended capability shown on old version");
  // Latency fields follow the common clock setting at the time of the read.
  a_l0s_read: assert property ( // [R4]
    @(posedge core_clk) disable iff (!rst_n)
    s_cap_read |=> cfg_rdata[14:12] == ($past(common_clk) ?
      $past(nv_word_l0s[`PLC_NV_L0S_COM_LSB +: 3]) :
      $past(nv_word_l0s[`PLC_NV_L0S_SEP_LSB +: 3])))
    else $error("exit latency for L0s misread");
  a_l1_read: assert property ( // [R5]
    @(posedge core_clk) disable iff (!rst_n)
    s_cap_read |=> cfg_rdata[17:15] == ($past(common_clk) ?
      $past(nv_deep_exit_word[`PLC_NV_L1_COM_LSB +: 3]) :
      $past(nv_deep_exit_word[`PLC_NV_L1_SEP_LSB +: 3])))
    else $error("exit latency for L1 misread");
  a_slot_read: assert property ( // [R19]
    @(posedge core_clk) disable iff (!rst_n)
    s_link_read |=>
    cfg_rdata[28] == $past(nv_word_clk[`PLC_NV_SLOT_CLK_BIT]))
    else $error("slot clock bit misread");
  a_train_read: assert property ( // [R18]
    @(posedge core_clk) disable iff (!rst_n)
    s_link_read |=> cfg_rdata[27] == $past(s_q.train))
    else $error("training flag misread");
  // Training flag and port number capture.
  a_train_set: assert property ( // [R18]
    @(posedge core_clk) disable iff (!rst_n)
    s_train_high |=> s_q.train)
    else $error("training flag did not rise");
  a_train_clear: assert property ( // [R18]
    @(posedge core_clk) disable iff (!rst_n)
    s_train_low |=> !s_q.train)
    else $error("training flag did not fall");
  a_port_take: assert property ( // [R8]
    @(posedge core_clk) disable iff (!rst_n)
    port_num_valid && s_q.train && !flr_req |=>
    s_q.port == $past(port_num))
    else $error("port number not taken");
  a_port_hold: assert property ( // [R8]
    @(posedge core_clk) disable iff (!rst_n)
    !s_q.train |=> $stable(s_q.port))
    else $error("port number changed outside training");
  // Control writes and the bits that must ignore them.
  a_ctrl_write: assert property ( // [R9]
    @(posedge core_clk) disable iff (!rst_n)
    cfg_wr && cfg_be[0] && dw_addr == `PLC_OFS_LINK_POWER && !flr_req
    |=> ##1 tx_l0s_en == $past(cfg_wdata[0], 2))
    else $error("power control write lost");
  a_l1_write: assert property ( // [R9]
    @(posedge core_clk) disable iff (!rst_n)
    s_ctrl_write |=> ##1 tx_l1_en == $past(cfg_wdata[1], 2))
    else $error("L1 enable write lost");
  a_rcb_write: assert property ( // [R11]
    @(posedge core_clk) disable iff (!rst_n)
    s_ctrl_write |=> rcb_128 == $past(cfg_wdata[3]))
    else $error("completion boundary write lost");
  a_clock_write: assert property ( // [R13]
    @(posedge core_clk) disable iff (!rst_n)
    s_ctrl_write |=> common_clk == $past(cfg_wdata[6]))
    else $error("common clock write lost");
  a_sync_write: assert property ( // [R14]
    @(posedge core_clk) disable iff (!rst_n)
    s_ctrl_write |=> ext_sync == $past(cfg_wdata[7]))
    else $error("extended sync write lost");
  a_ro_write: assert property ( // [R23]
    @(posedge core_clk) disable iff (!rst_n)
    cfg_wr && !(cfg_be[0] && dw_addr == `PLC_OFS_LINK_POWER) |=>
    $stable(rcb_128) && $stable(common_clk) && $stable(ext_sync))
    else $error("write to a read-only field took effect");
  a_rx_l0s: assert property ( // [R10]
    @(posedge core_clk) disable iff (!rst_n)
    rx_l0s_req |=> rx_l0s_en)
    else $error("receiver L0s blocked");
  a_flr_keep: assert property ( // [R13]
    @(posedge core_clk) disable iff (!rst_n)
    flr_req && !cfg_wr |=> $stable(common_clk) && $stable(ext_sync))
    else $error("function reset changed control bits");
endmodule

// [rtl/plc_regs.svh]
// Offsets, field positions, fixed values and reset values of the link
// capability register group. Included by the design files.
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH

`define PLC_OFS_LINK_ABILITY 12'h0AC
`define PLC_OFS_LINK_POWER 12'h0B0
`define PLC_OFS_LINK_STATE 12'h0B2
`define PLC_OFS_DEV_ABILITY_EXT 12'h0C4

`define PLC_MAX_SPEED 4'h2
`define PLC_MAX_WIDTH 6'h01
`define PLC_PM_SUPPORT 2'h3
`define PLC_PM_OPTIONAL 1'h1
`define PLC_NEG_SPEED 4'h1
`define PLC_NEG_WIDTH 6'h01
`define PLC_TMO_RANGES 4'hF
`define PLC_TMO_DISABLE_OK 1'h1
`define PLC_EXT_RSVD11 1'h1
`define PLC_CAP_VER_MIN 4'h2

`define PLC_PORT_RESET 8'h00
`define PLC_PM_CTRL_RESET 2'h0
`define PLC_SLOT_CLK_RESET 1'h1
`define PLC_LAT_RESET 3'h0

`define PLC_NV_WORD_L0S 8'h18
`define PLC_NV_WORD_L1 8'h14
`define PLC_NV_WORD_CLK 8'h1A

`define PLC_NV_L0S_SEP_LSB 0
`define PLC_NV_L0S_COM_LSB 3
`define PLC_NV_L1_SEP_LSB 0
`define PLC_NV_L1_COM_LSB 3
`define PLC_NV_SLOT_CLK_BIT 14

`endif

// [rtl/plc_pkg.sv]
// Types shared by the link capability register group.
// Assumes plc_regs.svh sits on the include path.
package plc_pkg;
  typedef logic [2:0] plc_lat_t;
  typedef logic [15:0] plc_half_t;
  typedef logic [31:0] plc_word_t;
endpackage

// [rtl/plc_nv_latch.sv]
// Small holding register for words fetched from nonvolatile configuration.
// Assumes the loader presents one word with a one-cycle strobe.
`timescale 1ns/10ps
module plc_nv_latch
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Load side
  input wire logic nv_load,
  input wire logic [7:0] nv_addr,
  input wire logic [15:0] nv_data,
  // Held words
  output logic [15:0] nv_word_l0s,
  output logic [15:0] nv_deep_exit_word,
  output logic [15:0] nv_word_clk
);
  import plc_pkg::*;
  `include "plc_regs.svh"

  typedef struct packed {
    logic [15:0] l0s;
    logic [15:0] l1;
    logic [15:0] clk;
  } plc_nv_state_t;

  plc_nv_state_t s_q;
  plc_nv_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (nv_load && nv_addr == `PLC_NV_WORD_L0S)
    begin
      s_d.l0s = nv_data;
    end
    if (nv_load && nv_addr == `PLC_NV_WORD_L1)
    begin
      s_d.l1 = nv_data;
    end
    if (nv_load && nv_addr == `PLC_NV_WORD_CLK)
    begin
      s_d.clk = nv_data;
    end
  end

  // The slot clock bit defaults to one until the word is loaded.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_q <= '{l0s: 16'h0000, l1: 16'h0000, clk: 16'h4000};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign nv_word_l0s = s_q.l0s;
  assign nv_deep_exit_word = s_q.l1;
  assign nv_word_clk = s_q.clk;
endmodule

// [test/plc_host_model.sv]
// Host agent that issues configuration reads and writes.
// Assumes the registers answer a read one cycle after its strobe.
`timescale 1ns/10ps
module plc_host_model
#(
  parameter bit ROOT_RCB_128 = 1'b1
)
(
  // Clock
  input wire logic core_clk,
  // Configuration access
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [11:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  initial
  begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
  end

  // Idle address and data show the inverse so stale values never match.
  task automatic wr_cfg(input logic [11:0] a, input logic [3:0] be,
                        input logic [31:0] d);
    logic [31:0] w;
    w = d;
    if (!ROOT_RCB_128) w[3] = 1'b0;
    @(negedge core_clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, w};
    @(negedge core_clk);
    {cfg_wr, cfg_addr, cfg_wdata} = {1'b0, ~a, ~w};
  endtask

  task automatic rd_cfg(input logic [11:0] a, output logic [31:0] d,
                        output logic v);
    @(negedge core_clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge core_clk);
    {cfg_rd, cfg_addr} = {1'b0, ~a};
    v = cfg_rvalid;
    d = cfg_rdata;
  endtask
endmodule

// [test/pcie_link_capability_regs_tb_top.sv]
// Self-checking bench for the link register group with a host agent.
// Assumes plc_pkg and plc_host_model are compiled first.
`timescale 1ns/10ps
module pcie_link_capability_regs_tb_top;
  import plc_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, flr_req = 1'b0, nv_load = 1'b0;
  logic [7:0] nv_addr = 8'h00, port_num = 8'h00;
  logic [15:0] nv_data = 16'h0000;
  logic [3:0] cap_version = 4'h2, cfg_be;
  logic train_active = 1'b0, port_num_valid = 1'b0, rx_l0s_req = 1'b0;
  logic cfg_wr, cfg_rd, cfg_rvalid;
  logic [11:0] cfg_addr, a;
  logic [31:0] cfg_wdata, r;
  plc_word_t cfg_rdata;
  logic tx_l0s_en, tx_l1_en, rx_l0s_en, ext_sync, rcb_128, common_clk;
  int errors = 0, tests_run = 0;
  logic [31:0] seed = 32'h0000000F;
  logic [15:0] nv18 = 16'h0000, nv14 = 16'h0000;
  logic [7:0] ctl_m = 8'h00, port_m = 8'h00;
  logic slot_m = 1'b1, train_m = 1'b0;

  always #5 core_clk = ~core_clk;

  plc_host_model host_u (.core_clk(core_clk), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
  plc_link_regs dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .flr_req(flr_req), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .nv_load(nv_load),
    .nv_addr(nv_addr), .nv_data(nv_data), .cap_version(cap_version),
    .train_active(train_active), .port_num_valid(port_num_valid),
    .port_num(port_num), .rx_l0s_req(rx_l0s_req), .tx_l0s_en(tx_l0s_en),
    .tx_l1_en(tx_l1_en), .rx_l0s_en(rx_l0s_en), .ext_sync(ext_sync),
    .rcb_128(rcb_128), .common_clk(common_clk));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_cap();
    logic [2:0] l0s, l1;
    l0s = ctl_m[6] ? nv18[5:3] : nv18[2:0];
    l1 = ctl_m[6] ? nv14[5:3] : nv14[2:0];
    return {port_m, 2'b01, 4'h0, l1, l0s, 2'h3, 6'h01, 4'h2};
  endfunction

  function automatic logic [31:0] exp_lnk();
    return {3'b000, slot_m, train_m, 1'b0, 6'h01, 4'h1, 8'h00, ctl_m};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_rd(input string what, input logic [11:0] ad,
                        input logic [31:0] e);
    logic [31:0] d;
    logic v;
    host_u.rd_cfg(ad, d, v);
    check({what, " valid"}, {31'h0, v}, 32'h1);
    check(what, d, e);
  endtask

  task automatic wr_ctl(input logic [11:0] ad, input logic [3:0] be,
                        input logic [31:0] d);
    host_u.wr_cfg(ad, be, d);
    if (ad[11:2] == 10'h02C && be[0]) ctl_m = d[7:0] & 8'hCB;
    @(negedge core_clk);
    check("ctl outs", {27'h0, ext_sync, common_clk, rcb_128, tx_l1_en,
          tx_l0s_en}, {27'h0, ctl_m[7], ctl_m[6], ctl_m[3], ctl_m[1],
          ctl_m[0]});
  endtask

  task automatic nvld(input logic [7:0] ad, input logic [15:0] d);
    @(negedge core_clk);
    {nv_load, nv_addr, nv_data} = {1'b1, ad, d};
    @(negedge core_clk);
    nv_load = 1'b0;
    if (ad == 8'h18) nv18 = d;
    if (ad == 8'h14) nv14 = d;
    if (ad == 8'h1A) slot_m = d[14];
  endtask

  task automatic close_out();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bounded well above the 136 cycles the sequence needs.
  initial
  begin
    #100000;
    errors++;
    close_out();
  end

  initial
  begin
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    chk_rd("cap", 12'h0AC, exp_cap());
    chk_rd("link", 12'h0B0, exp_lnk());
    chk_rd("ext", 12'h0C4, 32'h0000081F);
    r = xs();
    nvld(8'h18, r[15:0]);
    r = xs();
    nvld(8'h14, r[15:0]);
    r = xs();
    nvld(8'h1A, r[15:0]);
    for (int i = 0; i < 9; i++)
    begin
      r = xs();
      a = (i % 3 == 2) ? 12'h0AC : 12'h0B0;
      wr_ctl(a, r[11:8] | {3'b000, i < 2}, r);
      chk_rd("cap lat", 12'h0AC, exp_cap());
      chk_rd("link wr", 12'h0B2, exp_lnk());
    end
    wr_ctl(12'h0B0, 4'hF, 32'hFFFFFFFF);
    flr_req = 1'b1;
    repeat (3) @(negedge core_clk);
    flr_req = 1'b0;
    chk_rd("after flr", 12'h0B0, exp_lnk());
    train_active = 1'b1;
    repeat (8) @(negedge core_clk);
    r = xs();
    {port_num_valid, port_num} = {1'b1, r[7:0]};
    repeat (4) @(negedge core_clk);
    {port_m, train_m, port_num_valid} = {port_num, 2'b10};
    chk_rd("training", 12'h0B0, exp_lnk());
    train_active = 1'b0;
    repeat (8) @(negedge core_clk);
    {port_num_valid, port_num, train_m} = {1'b1, ~port_m, 1'b0};
    repeat (4) @(negedge core_clk);
    port_num_valid = 1'b0;
    chk_rd("port", 12'h0AC, exp_cap());
    chk_rd("link idle", 12'h0B0, exp_lnk());
    for (int i = 0; i < 2; i++)
    begin
      wr_ctl(12'h0B0, 4'h1, {30'h0, i[0], 1'b0});
      rx_l0s_req = 1'b1;
      repeat (4) @(negedge core_clk);
      check("rx l0s", {31'h0, rx_l0s_en}, 32'h1);
      rx_l0s_req = 1'b0;
    end
    cap_version = 4'h1;
    chk_rd("ext v1", 12'h0C4, 32'h0);
    chk_rd("unmapped", 12'h0B4, 32'h0);
    close_out();
  end
endmodule
